// ---- ddr2_init_mode_registers_tb_top.sv ----
`timescale 1ns/100ps
module ddr2_init_mode_registers_tb_top;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [13:0] mr_q, emr1_q, emr2_q, emr3_q, mr_cfg, emr1_cfg;
	logic [3:0] written_q;
	logic dll_on_q, dll_locked, self_ref_q;
	logic rd_q = 1'b0;
	logic lclk_q = 1'b0;
	logic [34:0] lq[$];
	logic [31:0] rq[$];
	int n_errors = 0;
	int total_checks = 0;
	ddrin_if link ();
	always #4 ref_clk = ~ref_clk;
	ddrin_ctrl #(.STABLE_CYCLES(200)) i_ddrin_ctrl (.ref_clk(ref_clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link(link.ctrl));
	ddrin_mem i_ddrin_mem (.ref_clk(ref_clk), .rst(rst), .link(link.mem), .mr_q(mr_q),
		.emr1_q(emr1_q), .emr2_q(emr2_q), .emr3_q(emr3_q), .written_q(written_q),
		.dll_on_q(dll_on_q), .dll_locked(dll_locked), .self_ref_q(self_ref_q));
	ddrin_asserts i_ddrin_asserts (.ref_clk(ref_clk), .rst(rst), .clk(link.clk), .cke(link.cke),
		.odt(link.odt), .cs_n(link.cs_n), .ras_n(link.ras_n), .cas_n(link.cas_n),
		.we_n(link.we_n), .ba(link.ba), .addr(link.addr));
	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("MISMATCH at %0t: %s", $time, msg);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 1'b0;
	endtask
	task automatic ex(input logic [3:0] c, input logic [2:0] b, input logic [13:0] m,
		input logic [13:0] v);
		lq.push_back({c, b, m, v});
	endtask
	// Commands are taken where the link clock has just risen, as the far end sees them.
	always @(posedge ref_clk) begin
		rd_q <= reg_rd;
		lclk_q <= link.clk;
		if (rd_q) begin
			chk(rq.size() > 0 && reg_rdata === rq.pop_front(), "register read data");
		end
		if (link.clk && !lclk_q && !link.cs_n && {link.ras_n, link.cas_n, link.we_n} != 3'h7) begin
			if (lq.size() == 0) begin
				chk(1'b0, "unexpected link command");
			end else begin
				chk({link.cs_n, link.ras_n, link.cas_n, link.we_n} === lq[0][34:31]
					&& (lq[0][34:31] != ddrin_pkg::CMD_MRS || link.ba === lq[0][30:28])
					&& (link.addr & lq[0][27:14]) === lq[0][13:0], "link command");
				void'(lq.pop_front());
			end
		end
	end
	task automatic init_seq(input logic srt);
		ex(ddrin_pkg::CMD_PRE, 3'h0, 14'h0400, 14'h0400);
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_EMR2, 14'h3FFF, {6'h0, srt, 7'h0});
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_EMR3, 14'h3FFF, 14'h0000);
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_EMR1, 14'h3FFF, emr1_cfg);
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_MR, 14'h0FFF, mr_cfg | 14'h0300);
		ex(ddrin_pkg::CMD_PRE, 3'h0, 14'h0400, 14'h0400);
		ex(ddrin_pkg::CMD_REF, 3'h0, 14'h0000, 14'h0000);
		ex(ddrin_pkg::CMD_REF, 3'h0, 14'h0000, 14'h0000);
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_MR, 14'h0FFF, mr_cfg | 14'h0200);
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_EMR1, 14'h3FFF, emr1_cfg | 14'h0380);
		ex(ddrin_pkg::CMD_MRS, ddrin_pkg::BA_EMR1, 14'h3FFF, emr1_cfg);
		wr(8'h00, {30'h0, srt, 1'b1});
		for (int i = 0; i < 8000 && lq.size() > 0; i++) begin
			@(posedge ref_clk);
		end
		chk(lq.size() == 0, "sequence incomplete");
		repeat (40) @(posedge ref_clk);
		rd(8'h04, 32'h0000001C);
		chk(emr2_q === {6'h0, srt, 7'h0}, "emr2 contents");
		chk(emr3_q === 14'h0000, "emr3 contents");
		chk(written_q === 4'hF, "registers programmed");
		chk(emr1_q === emr1_cfg, "emr1 contents");
		chk(mr_q === (mr_cfg | 14'h0200), "mr contents");
		chk(dll_on_q === 1'b1 && dll_locked === 1'b1 && self_ref_q === 1'b0, "dll state");
		$display("init sequence test done, self refresh rate %0d", srt);
	endtask
	initial begin
		void'($urandom(32'h7C70));
		mr_cfg = 14'({3'($urandom_range(5, 3)), 1'($urandom), 3'($urandom_range(3, 2))});
		emr1_cfg = 14'($urandom) & 14'h047E;
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		rd(8'h08, 32'h00000032);
		rd(8'hFC, 32'h00000000);
		wr(8'h08, 32'(mr_cfg));
		wr(8'h0C, 32'(emr1_cfg));
		rd(8'h0C, 32'(emr1_cfg));
		$display("register test done");
		init_seq(1'b1);
		init_seq(1'b0);
		tally_and_finish();
	end
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
endmodule

// ---- ddrin_asserts.sv ----
`timescale 1ns/100ps
module ddrin_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk,
	input wire logic cke,
	input wire logic odt,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [ddrin_pkg::BA_W-1:0] ba,
	input wire logic [ddrin_pkg::ADDR_W-1:0] addr
);
	localparam int LOCK_REF = ddrin_pkg::DLL_LOCK_CLK * ddrin_pkg::LINK_DIV;
	logic [3:0] cmd;
	logic mrs;
	logic nop;
	logic rise;
	logic clk_q;
	logic [5:0] cke_cnt_q;
	logic [11:0] lock_cnt_q;
	assign cmd = {cs_n, ras_n, cas_n, we_n};
	assign mrs = cmd == ddrin_pkg::CMD_MRS;
	assign nop = cs_n || cmd == ddrin_pkg::CMD_NOP;
	assign rise = clk && !clk_q;
	// Both counters saturate so that a long idle stretch cannot wrap them back under a limit.
	always_ff @(posedge ref_clk) begin
		clk_q <= clk;
		if (rst || !cke) begin
			cke_cnt_q <= 6'h00;
		end else begin
			cke_cnt_q <= cke_cnt_q + 6'(cke_cnt_q != 6'h3F);
		end
		if (rst || (rise && mrs && ba == ddrin_pkg::BA_MR && addr[8])) begin
			lock_cnt_q <= 12'h000;
		end else begin
			lock_cnt_q <= lock_cnt_q + 12'(lock_cnt_q != 12'hFFF);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_odt_low: assert property (odt == 1'b0) else $error("odt raised");
	a_cke_first: assert property ($rose(cke) |-> nop) else $error("command at cke rise");
	a_cke_quiet: assert property (cke && cke_cnt_q < 6'd50 |-> nop) else $error("early command");
	a_mode_cke: assert property (mrs |-> cke) else $error("mode write with cke low");
	a_ocd_wait: assert property (rise && mrs && ba == ddrin_pkg::BA_EMR1 && addr[9:7] == 3'h7
		|-> lock_cnt_q >= 12'(LOCK_REF)) else $error("ocd default too early");
	a_emr2_bits: assert property (mrs && ba == ddrin_pkg::BA_EMR2
		|-> (addr & 14'h3F7F) == 14'h0000) else $error("emr2 reserved bits set");
	a_emr3_zero: assert property (mrs && ba == ddrin_pkg::BA_EMR3 |-> addr == 14'h0000)
		else $error("emr3 not zero");
	a_mr_test: assert property (mrs && ba == ddrin_pkg::BA_MR |-> !addr[7])
		else $error("test mode set");
	// Commands move on the falling link clock so that they stand still across the rising one.
	a_cmd_step: assert property (!$stable({cmd, ba, addr}) |-> !clk && clk_q)
		else $error("command off falling edge");
	cover property (rise && mrs && ba == ddrin_pkg::BA_MR && addr[8]);
	cover property ($rose(cke));
	cover property (rise && cmd == ddrin_pkg::CMD_REF);
endmodule

// ---- ddrin_ctrl.sv ----
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/100ps
//Function
// - Hold CKE and ODT low at power-up.
// - Run clock 200 us before commands.
// - NOP present, then raise CKE.
// - NOPs for 400 ns, then precharge all.
// - Write EMR2 then EMR3.
// - Write EMR1 enabling DLL, OCD bits low.
// - MRS with A8 high resets DLL.
// - Precharge all, then two refreshes.
// - MRS with A8 low sets operation.
// - After 200 clocks, OCD default then exit.
// - Every write supplies all register fields.
// - Mode writes never touch array contents.
// - Write modes precharged, CKE high, wait tMRD.
// - Mode registers undefined until programmed.
// - MR burst length, type, CAS latency fields.
// - MR A8 DLL reset, A7 test low.
// - MR write recovery rounded up cycles.
// - EMR1 field layout DLL, drive, AL, OCD.
// - Self refresh disables, exit resets DLL.
// - Wait 200 clocks after DLL reset before reads.
// - EMR2 zero except A7 self-refresh rate.
// - EMR3 all zero.
module ddrin_ctrl #(
	parameter int STABLE_CYCLES = ddrin_pkg::STABLE_CYC,
	parameter int T_WR_NS = 15,
	parameter int T_CK_NS = 8
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	ddrin_if.ctrl link
);
	localparam logic [7:0] OFS_CTRL = ddrin_pkg::OFS_CTRL;
	localparam logic [7:0] OFS_STATUS = ddrin_pkg::OFS_STATUS;
	localparam logic [7:0] OFS_MR = ddrin_pkg::OFS_MR;
	localparam logic [7:0] OFS_EMR1 = ddrin_pkg::OFS_EMR1;
	localparam int WR_CYC = (T_WR_NS + T_CK_NS - 1) / T_CK_NS;
	localparam int CW = 16;

	typedef enum {S_IDLE, S_STABLE, S_CKE, S_PRE1, S_EMR2, S_EMR3, S_EMR1, S_DLLRST,
		S_PRE2, S_REF, S_OCDEXIT, S_WAIT, S_DONE} ddrin_state_e;

	ddrin_state_e st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [7:0] lock_q, lock_d;
	logic [1:0] nref_q, nref_d;
	logic [2:0] div_q, div_d;
	logic [3:0] cmd_q, cmd_d;
	logic [2:0] ba_q, ba_d;
	logic [13:0] a_q, a_d;
	logic cke_q, cke_d, lclk_q, lclk_d, start_q, start_d, srt_q, srt_d;
	logic [13:0] mr_cfg_q, mr_cfg_d, emr1_cfg_q, emr1_cfg_d;
	logic [31:0] rdata_d, rdata_q;
	logic edge_w;

	assign edge_w = (div_q == 3'(ddrin_pkg::LINK_DIV / 2 - 1)) && lclk_q;
	assign link.clk = lclk_q;
	assign link.cke = cke_q;
	// ODT stays low throughout; termination is not managed here.
	assign link.odt = 1'b0;
	assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = cmd_q;
	assign link.ba = ba_q;
	assign link.addr = a_q;
	assign reg_rdata = rdata_q;

	function automatic logic [13:0] mr_word(input logic [13:0] cfg, input logic dll_rst);
		logic [13:0] w;
		w = cfg;
		w[ddrin_pkg::MR_TM] = 1'b0;
		w[ddrin_pkg::MR_DLL_RST] = dll_rst;
		w[ddrin_pkg::MR_WR_LSB +: 3] = 3'(WR_CYC - 1);
		w[13:12] = 2'h0;
		return w;
	endfunction

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		lock_d = lock_q;
		nref_d = nref_q;
		cke_d = cke_q;
		cmd_d = cmd_q;
		ba_d = ba_q;
		a_d = a_q;
		start_d = start_q && !edge_w;
		srt_d = srt_q;
		mr_cfg_d = mr_cfg_q;
		emr1_cfg_d = emr1_cfg_q;
		div_d = (div_q == 3'(ddrin_pkg::LINK_DIV / 2 - 1)) ? 3'h0 : div_q + 3'h1;
		lclk_d = (div_q == 3'(ddrin_pkg::LINK_DIV / 2 - 1)) ? ~lclk_q : lclk_q;
		rdata_d = 32'h0;
		if (reg_wr) begin
			unique case (reg_addr)
				OFS_CTRL: begin
					start_d = start_d | reg_wdata[0];
					srt_d = reg_wdata[1];
				end
				OFS_MR: mr_cfg_d = reg_wdata[13:0];
				OFS_EMR1: emr1_cfg_d = reg_wdata[13:0];
				default: ;
			endcase
		end
		if (edge_w) begin
			cmd_d = ddrin_pkg::CMD_NOP;
			ba_d = 3'h0;
			a_d = 14'h0;
			if (cnt_q != '0)
				cnt_d = cnt_q - CW'(1);
			if (lock_q != 8'h0)
				lock_d = lock_q - 8'h1;
			unique case (st_q)
				S_IDLE: begin
					cke_d = 1'b0;
					cnt_d = CW'(STABLE_CYCLES / ddrin_pkg::LINK_DIV);
					if (start_q)
						st_d = S_STABLE;
				end
				S_STABLE: if (cnt_q == '0) begin
					cke_d = 1'b1;
					cnt_d = CW'(ddrin_pkg::CKE_CYC / ddrin_pkg::LINK_DIV + 1);
					st_d = S_CKE;
				end
				S_CKE: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_PRE;
					a_d[ddrin_pkg::A_PRE_ALL] = 1'b1;
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_EMR2;
				end
				S_EMR2: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_MRS;
					ba_d = ddrin_pkg::BA_EMR2;
					a_d[ddrin_pkg::EMR2_SRT] = srt_q;
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_EMR3;
				end
				S_EMR3: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_MRS;
					ba_d = ddrin_pkg::BA_EMR3;
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_EMR1;
				end
				S_EMR1: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_MRS;
					ba_d = ddrin_pkg::BA_EMR1;
					a_d = emr1_cfg_q;
					a_d[ddrin_pkg::EMR1_DLL_DIS] = 1'b0;
					a_d[ddrin_pkg::EMR1_OCD_LSB +: 3] = ddrin_pkg::OCD_EXIT;
					a_d[13] = 1'b0;
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_DLLRST;
				end
				S_DLLRST: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_MRS;
					ba_d = ddrin_pkg::BA_MR;
					a_d = mr_word(mr_cfg_q, 1'b1);
					lock_d = 8'(ddrin_pkg::DLL_LOCK_CLK);
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_PRE2;
				end
				S_PRE2: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_PRE;
					a_d[ddrin_pkg::A_PRE_ALL] = 1'b1;
					nref_d = 2'(ddrin_pkg::REF_COUNT);
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_REF;
				end
				S_REF: if (cnt_q == '0) begin
					if (nref_q != 2'h0) begin
						cmd_d = ddrin_pkg::CMD_REF;
						nref_d = nref_q - 2'h1;
						// Refresh cycle time is generous at one link clock per count.
						cnt_d = CW'(ddrin_pkg::T_RFC_CLK);
					end else begin
						cmd_d = ddrin_pkg::CMD_MRS;
						a_d = mr_word(mr_cfg_q, 1'b0);
						cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
						st_d = S_WAIT;
					end
				end
				S_WAIT: if (cnt_q == '0 && lock_q == 8'h0) begin
					cmd_d = ddrin_pkg::CMD_MRS;
					ba_d = ddrin_pkg::BA_EMR1;
					a_d = emr1_cfg_q;
					a_d[ddrin_pkg::EMR1_DLL_DIS] = 1'b0;
					a_d[ddrin_pkg::EMR1_OCD_LSB +: 3] = ddrin_pkg::OCD_DEFAULT;
					a_d[13] = 1'b0;
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_OCDEXIT;
				end
				S_OCDEXIT: if (cnt_q == '0) begin
					cmd_d = ddrin_pkg::CMD_MRS;
					ba_d = ddrin_pkg::BA_EMR1;
					a_d = emr1_cfg_q;
					a_d[ddrin_pkg::EMR1_DLL_DIS] = 1'b0;
					a_d[ddrin_pkg::EMR1_OCD_LSB +: 3] = ddrin_pkg::OCD_EXIT;
					a_d[13] = 1'b0;
					cnt_d = CW'(ddrin_pkg::T_MRD_CLK);
					st_d = S_DONE;
				end
				S_DONE: if (start_q) begin
					cnt_d = CW'(STABLE_CYCLES / ddrin_pkg::LINK_DIV);
					st_d = S_STABLE;
				end
				default: st_d = S_IDLE;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				OFS_STATUS: rdata_d = {27'h0, lock_q == 8'h0, cke_q, st_q == S_DONE,
					st_q != S_IDLE && st_q != S_DONE, 1'b0};
				OFS_MR: rdata_d = {18'h0, mr_cfg_q};
				OFS_EMR1: rdata_d = {18'h0, emr1_cfg_q};
				OFS_CTRL: rdata_d = {30'h0, srt_q, 1'b0};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= S_IDLE;
			cnt_q <= '0;
			lock_q <= 8'h0;
			nref_q <= 2'h0;
			div_q <= 3'h0;
			lclk_q <= 1'b0;
			cke_q <= 1'b0;
			cmd_q <= ddrin_pkg::CMD_NOP;
			ba_q <= 3'h0;
			a_q <= 14'h0;
			start_q <= 1'b0;
			srt_q <= 1'b0;
			mr_cfg_q <= ddrin_pkg::MR_CFG_RST;
			emr1_cfg_q <= 14'h0000;
			rdata_q <= 32'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			lock_q <= lock_d;
			nref_q <= nref_d;
			div_q <= div_d;
			lclk_q <= lclk_d;
			cke_q <= cke_d;
			cmd_q <= cmd_d;
			ba_q <= ba_d;
			a_q <= a_d;
			start_q <= start_d;
			srt_q <= srt_d;
			mr_cfg_q <= mr_cfg_d;
			emr1_cfg_q <= emr1_cfg_d;
			rdata_q <= rdata_d;
		end
	end
endmodule

// ---- ddrin_if.sv ----
`timescale 1ns/100ps
interface ddrin_if;
	logic clk;
	logic cke;
	logic odt;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [ddrin_pkg::BA_W-1:0] ba;
	logic [ddrin_pkg::ADDR_W-1:0] addr;
	modport ctrl (output clk, output cke, output odt, output cs_n, output ras_n, output cas_n,
		output we_n, output ba, output addr);
	modport mem (input clk, input cke, input odt, input cs_n, input ras_n, input cas_n,
		input we_n, input ba, input addr);
endinterface

// ---- ddrin_mem.sv ----
`timescale 1ns/100ps
// Memory end: decodes register writes and tracks DLL state.
module ddrin_mem (
	input wire logic ref_clk,
	input wire logic rst,
	ddrin_if.mem link,
	output logic [13:0] mr_q,
	output logic [13:0] emr1_q,
	output logic [13:0] emr2_q,
	output logic [13:0] emr3_q,
	output logic [3:0] written_q,
	output logic dll_on_q,
	output logic dll_locked,
	output logic self_ref_q
);
	logic [2:0] ck_sync_q;
	logic [2:0] ck_sync_d;
	logic ck_lvl_q, ck_lvl_d, rise_w;
	logic [13:0] mr_d, emr1_d, emr2_d, emr3_d;
	logic [3:0] written_d;
	logic dll_on_d, self_ref_d, cke_prev_q, cke_prev_d, locked_q, locked_d;
	logic [7:0] lock_q, lock_d;
	logic [3:0] cmd_w;

	assign cmd_w = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
	assign rise_w = (ck_sync_q[1] == ck_sync_q[2]) && ck_sync_q[2] && !ck_lvl_q;
	assign dll_locked = locked_q;

	always_comb begin
		ck_sync_d = {ck_sync_q[1:0], link.clk};
		ck_lvl_d = (ck_sync_q[1] == ck_sync_q[2]) ? ck_sync_q[2] : ck_lvl_q;
		mr_d = mr_q;
		emr1_d = emr1_q;
		emr2_d = emr2_q;
		emr3_d = emr3_q;
		written_d = written_q;
		dll_on_d = dll_on_q;
		self_ref_d = self_ref_q;
		cke_prev_d = cke_prev_q;
		lock_d = lock_q;
		if (rise_w) begin
			cke_prev_d = link.cke;
			if (lock_q != 8'h0)
				lock_d = lock_q - 8'h1;
			if (self_ref_q && link.cke) begin
				self_ref_d = 1'b0;
				dll_on_d = 1'b1;
				lock_d = 8'(ddrin_pkg::DLL_LOCK_CLK);
			end else if (cke_prev_q && link.cke && cmd_w == ddrin_pkg::CMD_MRS) begin
				unique case (link.ba)
					ddrin_pkg::BA_MR: begin
						mr_d = link.addr;
						written_d[0] = 1'b1;
						if (link.addr[ddrin_pkg::MR_DLL_RST])
							lock_d = 8'(ddrin_pkg::DLL_LOCK_CLK);
					end
					ddrin_pkg::BA_EMR1: begin
						emr1_d = link.addr;
						written_d[1] = 1'b1;
						dll_on_d = !link.addr[ddrin_pkg::EMR1_DLL_DIS];
					end
					ddrin_pkg::BA_EMR2: begin
						emr2_d = link.addr;
						written_d[2] = 1'b1;
					end
					ddrin_pkg::BA_EMR3: begin
						emr3_d = link.addr;
						written_d[3] = 1'b1;
					end
					default: ;
				endcase
			end else if (cke_prev_q && !link.cke && cmd_w == ddrin_pkg::CMD_REF) begin
				self_ref_d = 1'b1;
				dll_on_d = 1'b0;
			end
		end
		locked_d = dll_on_d && lock_d == 8'h0;
	end

	// registers hold no valid value until written
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ck_sync_q <= 3'h0;
			ck_lvl_q <= 1'b0;
			mr_q <= 14'h0;
			emr1_q <= 14'h0;
			emr2_q <= 14'h0;
			emr3_q <= 14'h0;
			written_q <= 4'h0;
			dll_on_q <= 1'b0;
			self_ref_q <= 1'b0;
			cke_prev_q <= 1'b0;
			lock_q <= 8'h0;
			locked_q <= 1'b0;
		end else begin
			ck_sync_q <= ck_sync_d;
			ck_lvl_q <= ck_lvl_d;
			mr_q <= mr_d;
			emr1_q <= emr1_d;
			emr2_q <= emr2_d;
			emr3_q <= emr3_d;
			written_q <= written_d;
			dll_on_q <= dll_on_d;
			self_ref_q <= self_ref_d;
			cke_prev_q <= cke_prev_d;
			lock_q <= lock_d;
			locked_q <= locked_d;
		end
	end
endmodule

// ---- ddrin_pkg.sv ----
package ddrin_pkg;
	localparam int ADDR_W = 14;
	localparam int BA_W = 3;
	localparam logic [2:0] BA_MR = 3'h0;
	localparam logic [2:0] BA_EMR1 = 3'h1;
	localparam logic [2:0] BA_EMR2 = 3'h2;
	localparam logic [2:0] BA_EMR3 = 3'h3;
	// Command codes as {cs_n, ras_n, cas_n, we_n}.
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESEL = 4'h8;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam int A_PRE_ALL = 10;
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_TM = 7;
	localparam int MR_DLL_RST = 8;
	localparam int MR_WR_LSB = 9;
	localparam int EMR1_DLL_DIS = 0;
	localparam int EMR1_AL_LSB = 3;
	localparam int EMR1_OCD_LSB = 7;
	localparam int EMR2_SRT = 7;
	localparam logic [2:0] OCD_EXIT = 3'h0;
	localparam logic [2:0] OCD_DEFAULT = 3'h7;
	localparam int CLK_MHZ = 125;
	localparam int T_STABLE_US = 200;
	localparam int STABLE_CYC = T_STABLE_US * CLK_MHZ;
	localparam int T_CKE_NS = 400;
	localparam int CKE_CYC = (T_CKE_NS * CLK_MHZ + 999) / 1000;
	localparam int DLL_LOCK_CLK = 200;
	localparam int T_MRD_CLK = 2;
	localparam int REF_COUNT = 2;
	localparam int LINK_DIV = 10;
	localparam int T_RFC_CLK = 16;
	localparam logic [13:0] MR_CFG_RST = 14'h0032;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MR = 8'h08;
	localparam logic [7:0] OFS_EMR1 = 8'h0C;
endpackage
